// >>> common/timer_unit_one_pkg.sv
// Register map, field layout and encodings of the 16-bit timer/counter
package timer_unit_one_pkg;

    // ----------------------------------------------------------------
    // Register indices and APB byte addresses
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] IDX_COMPARE_A = 8'h10;
    localparam logic [ADDR_W-1:0] IDX_COMPARE_B = 8'h12;
    localparam logic [ADDR_W-1:0] IDX_CONTROL = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_COMPARE_A = 8'h40;
    localparam logic [ADDR_W-1:0] ADDR_COMPARE_B = 8'h48;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h50;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] COMPARE_RESET = 16'hFFFF;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int CTL_FLIPFLOP_BIT = 7;
    localparam int CTL_OPTION_BIT = 6;
    localparam int CTL_START_HI = 5;
    localparam int CTL_START_LO = 4;
    localparam int CTL_CLOCK_HI = 3;
    localparam int CTL_CLOCK_LO = 2;
    localparam int CTL_MODE_HI = 1;
    localparam int CTL_MODE_LO = 0;

    // Start control codes
    localparam logic [1:0] START_STOP = 2'h0;
    localparam logic [1:0] START_COMMAND = 2'h1;
    localparam logic [1:0] START_RISING = 2'h2;
    localparam logic [1:0] START_FALLING = 2'h3;

    // Source clock codes
    localparam logic [1:0] CLK_SLOWEST = 2'h0;
    localparam logic [1:0] CLK_MEDIUM = 2'h1;
    localparam logic [1:0] CLK_FASTEST = 2'h2;
    localparam logic [1:0] CLK_EXTERNAL = 2'h3;

    // Operating mode codes
    localparam logic [1:0] MODE_TIMER = 2'h0;
    localparam logic [1:0] MODE_WINDOW = 2'h1;
    localparam logic [1:0] MODE_PULSE_WIDTH = 2'h2;
    localparam logic [1:0] MODE_PULSE_OUT = 2'h3;

    // ----------------------------------------------------------------
    // Prescaler exponents: divide by 2**n
    // ----------------------------------------------------------------
    localparam int DIV_FAST_EXP = 3;
    localparam int DIV_MEDIUM_EXP = 7;
    localparam int DIV_SLOW_EXP = 11;
    localparam int DIV_LOW_CLK_EXP = 3;

    // Counter states, Gray coded along idle -> run
    typedef enum logic [1:0] {
        CNT_IDLE = 2'b00,
        CNT_RUN = 2'b01,
        CNT_HOLD = 2'b11
    } count_state_e;

endpackage

// >>> src/source_clock_divider.sv
// Prescaler producing one-cycle enable pulses for the timer source clocks
`timescale 1ns/1ps
`default_nettype none

module source_clock_divider #(
    parameter int SLOW_EXP = timer_unit_one_pkg::DIV_SLOW_EXP,
    parameter int MEDIUM_EXP = timer_unit_one_pkg::DIV_MEDIUM_EXP,
    parameter int FAST_EXP = timer_unit_one_pkg::DIV_FAST_EXP,
    parameter int LOW_EXP = timer_unit_one_pkg::DIV_LOW_CLK_EXP
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic low_clk,
    output logic tick_fast,
    output logic tick_medium,
    output logic tick_slow,
    output logic tick_low
);
    import timer_unit_one_pkg::*;

    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    if (!(FAST_EXP > 0 && FAST_EXP < MEDIUM_EXP && MEDIUM_EXP < SLOW_EXP && LOW_EXP > 0))
        $error("source_clock_divider: exponents must be ascending and positive");

    logic [SLOW_EXP-1:0] pre_reg, pre_next;
    logic [LOW_EXP-1:0] low_cnt_reg, low_cnt_next;
    logic low_meta_reg, low_sync_reg, low_prev_reg;
    logic fast_next, medium_next, slow_next, low_next;

    // Free-running prescaler; each tap fires when its low bits are all ones
    always_comb begin
        pre_next = pre_reg + 1'b1;
        fast_next = &pre_reg[FAST_EXP-1:0];
        medium_next = &pre_reg[MEDIUM_EXP-1:0];
        slow_next = &pre_reg;
        low_cnt_next = low_cnt_reg;
        low_next = 1'b0;
        // Low clock is asynchronous: only the synchronised copy is edge-detected
        if (low_sync_reg && !low_prev_reg) begin
            low_cnt_next = low_cnt_reg + 1'b1;
            low_next = &low_cnt_reg;
        end
    end

    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= '0;
            low_cnt_reg <= '0;
            low_meta_reg <= 1'b0;
            low_sync_reg <= 1'b0;
            low_prev_reg <= 1'b0;
            tick_fast <= 1'b0;
            tick_medium <= 1'b0;
            tick_slow <= 1'b0;
            tick_low <= 1'b0;
        end else begin
            pre_reg <= pre_next;
            low_cnt_reg <= low_cnt_next;
            low_meta_reg <= low_clk;
            low_sync_reg <= low_meta_reg;
            low_prev_reg <= low_sync_reg;
            tick_fast <= fast_next;
            tick_medium <= medium_next;
            tick_slow <= slow_next;
            tick_low <= low_next;
        end
    end

endmodule // source_clock_divider

`default_nettype wire

// >>> src/timer_unit_one.sv
// 16-bit timer/counter with APB register file, compare, capture and pulse output
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Both compare registers reset to all ones.
// - Register B accepts writes only in pulse output mode.
// - Control register resets to zero; counter stopped and cleared.
// - Written values become active on first source tick after high byte write.
// - Low byte alone never updates the active value; write low then high.
// - Start codes: stop and clear, command start, rising or falling edge.
// - Clock codes: div 2048 or low/8, div 128, div 8, external pin.
// - Mode codes: timer/trigger/event, window, pulse width, pulse output.
// - Option bit picks trigger start only, or start and stop.
// - Stop mode entry forces start field to zero and halts the counter.
// - Capture copies on source ticks, pulse width on the stop edge; software waits one tick before reading.
// - Timer match with A raises interrupt, clears counter; keeps counting unless edge-triggered.
// - Auto-capture copies the running count into register B every tick.
module timer_unit_one (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [timer_unit_one_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic stop_mode_entry,
    input wire logic slow_mode,
    input wire logic divider_clock_option,
    input wire logic low_clk,
    input wire logic timer_pin,
    output logic match_interrupt,
    output logic pulse_out
);
    import timer_unit_one_pkg::*;

    // ----------------------------------------------------------------
    // Source clock selection
    // ----------------------------------------------------------------
    logic tick_fast, tick_medium, tick_slow, tick_low;
    logic pin_meta_reg, pin_sync_reg, pin_prev_reg;
    logic pin_rise, pin_fall, src_tick;
    logic [7:0] ctl_reg, ctl_next;
    logic [1:0] start_f, clock_f, mode_f;

    source_clock_divider u_divider (
        .pclk(pclk),
        .presetn(presetn),
        .low_clk(low_clk),
        .tick_fast(tick_fast),
        .tick_medium(tick_medium),
        .tick_slow(tick_slow),
        .tick_low(tick_low)
    );

    assign start_f = ctl_reg[CTL_START_HI:CTL_START_LO];
    assign clock_f = ctl_reg[CTL_CLOCK_HI:CTL_CLOCK_LO];
    assign mode_f = ctl_reg[CTL_MODE_HI:CTL_MODE_LO];
    assign pin_rise = pin_sync_reg && !pin_prev_reg;
    assign pin_fall = !pin_sync_reg && pin_prev_reg;

    // Tick mux; in slow mode the fast sources are dead, so only codes 00 and 11 run
    always_comb begin
        case (clock_f)
            CLK_SLOWEST: src_tick = (slow_mode || divider_clock_option) ? tick_low : tick_slow;
            CLK_MEDIUM: src_tick = tick_medium && !slow_mode;
            CLK_FASTEST: src_tick = tick_fast && !slow_mode;
            CLK_EXTERNAL: src_tick = (start_f == START_FALLING) ? pin_fall : pin_rise;
            default: src_tick = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // APB register file
    // ----------------------------------------------------------------
    logic [15:0] a_shadow_reg, a_shadow_next, a_active_reg, a_active_next;
    logic [15:0] b_shadow_reg, b_shadow_next, b_active_reg, b_active_next;
    logic a_pend_reg, a_pend_next, b_pend_reg, b_pend_next;
    logic [31:0] rdata_next;
    logic ready_next, err_next, wr_access, mapped;
    logic capture_req;
    logic [15:0] capture_val;

    // Access phase completes in the cycle after setup, so writes land there
    assign wr_access = psel && penable && pready && pwrite;
    assign mapped = (paddr == ADDR_COMPARE_A) || (paddr == ADDR_COMPARE_B) ||
                    (paddr == ADDR_CONTROL);

    // Next-state for registers, read data and shadow buffers
    always_comb begin
        ctl_next = ctl_reg;
        a_shadow_next = a_shadow_reg;
        b_shadow_next = b_shadow_reg;
        a_active_next = a_active_reg;
        b_active_next = b_active_reg;
        a_pend_next = a_pend_reg;
        b_pend_next = b_pend_reg;
        ready_next = psel && !penable;
        err_next = psel && !penable && !mapped;
        rdata_next = prdata;
        if (psel && !penable) begin
            case (paddr)
                ADDR_COMPARE_A: rdata_next = {16'h0000, a_active_reg};
                ADDR_COMPARE_B: rdata_next = {16'h0000, b_active_reg};
                ADDR_CONTROL: rdata_next = {24'h000000, ctl_reg};
                default: rdata_next = 32'h00000000;
            endcase
        end
        // Shadow loads promote on a tick; a high-byte write in that cycle re-arms
        if (src_tick && a_pend_reg) begin
            a_active_next = a_shadow_reg;
            a_pend_next = 1'b0;
        end
        if (src_tick && b_pend_reg) begin
            b_active_next = b_shadow_reg;
            b_pend_next = 1'b0;
        end
        if (capture_req) begin
            b_active_next = capture_val;
        end
        if (wr_access && paddr == ADDR_COMPARE_A) begin
            if (pstrb[0]) a_shadow_next[7:0] = pwdata[7:0];
            if (pstrb[1]) begin
                a_shadow_next[15:8] = pwdata[15:8];
                a_pend_next = 1'b1;
            end
        end
        // Writes to B outside pulse output mode are dropped without error
        if (wr_access && paddr == ADDR_COMPARE_B && mode_f == MODE_PULSE_OUT) begin
            if (pstrb[0]) b_shadow_next[7:0] = pwdata[7:0];
            if (pstrb[1]) begin
                b_shadow_next[15:8] = pwdata[15:8];
                b_pend_next = 1'b1;
            end
        end
        if (wr_access && paddr == ADDR_CONTROL && pstrb[0]) begin
            ctl_next = pwdata[7:0];
        end
        // Hardware stop beats a simultaneous software start
        if (stop_mode_entry) begin
            ctl_next[CTL_START_HI:CTL_START_LO] = START_STOP;
        end
    end

    // Registers; compare values come up at all ones, control at zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_reg <= CONTROL_RESET;
            a_shadow_reg <= COMPARE_RESET;
            b_shadow_reg <= COMPARE_RESET;
            a_active_reg <= COMPARE_RESET;
            b_active_reg <= COMPARE_RESET;
            a_pend_reg <= 1'b0;
            b_pend_reg <= 1'b0;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            ctl_reg <= ctl_next;
            a_shadow_reg <= a_shadow_next;
            b_shadow_reg <= b_shadow_next;
            a_active_reg <= a_active_next;
            b_active_reg <= b_active_next;
            a_pend_reg <= a_pend_next;
            b_pend_reg <= b_pend_next;
            prdata <= rdata_next;
            pready <= ready_next;
            pslverr <= err_next;
        end
    end

    // ----------------------------------------------------------------
    // Up-counter and mode sequencing
    // ----------------------------------------------------------------
    count_state_e state_reg, state_next;
    logic [15:0] cnt_reg, cnt_next;
    logic irq_next, out_next;
    logic start_edge, stop_edge, window_level, match_a, match_b, option;

    assign option = ctl_reg[CTL_OPTION_BIT];
    assign start_edge = (start_f == START_RISING) ? pin_rise : pin_fall;
    assign stop_edge = (start_f == START_RISING) ? pin_fall : pin_rise;
    assign window_level = (start_f == START_RISING) ? pin_sync_reg : !pin_sync_reg;
    assign match_a = (cnt_reg == a_active_reg);
    assign match_b = (cnt_reg == b_active_reg);

    // Counter next-state; start code 00 always stops and clears
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        irq_next = 1'b0;
        out_next = pulse_out;
        capture_req = 1'b0;
        capture_val = cnt_reg;
        if (start_f == START_STOP) begin
            state_next = CNT_IDLE;
            cnt_next = 16'h0000;
            // Idle level of the pulse pin follows the flip-flop control bit in pulse output mode, else low
            out_next = ctl_reg[CTL_FLIPFLOP_BIT] && (mode_f == MODE_PULSE_OUT);
        end else begin
            case (mode_f)
                MODE_TIMER: begin
                    if (start_f == START_COMMAND || clock_f == CLK_EXTERNAL) begin
                        // Timer or event counter: free run, clear on match
                        state_next = CNT_RUN;
                        if (src_tick) begin
                            if (match_a) begin
                                cnt_next = 16'h0000;
                                irq_next = 1'b1;
                            end else begin
                                cnt_next = cnt_reg + 16'h0001;
                            end
                            capture_req = option;
                        end
                    end else if (state_reg != CNT_RUN) begin
                        if (start_edge) state_next = CNT_RUN;
                    end else if (option && stop_edge) begin
                        state_next = CNT_IDLE;
                        cnt_next = 16'h0000;
                    end else if (src_tick) begin
                        capture_req = option;
                        if (match_a) begin
                            state_next = CNT_IDLE;
                            cnt_next = 16'h0000;
                            irq_next = 1'b1;
                        end else begin
                            cnt_next = cnt_reg + 16'h0001;
                        end
                    end
                end
                MODE_WINDOW: begin
                    state_next = window_level ? CNT_RUN : CNT_HOLD;
                    if (src_tick && window_level) begin
                        capture_req = option;
                        if (match_a) begin
                            cnt_next = 16'h0000;
                            irq_next = 1'b1;
                        end else begin
                            cnt_next = cnt_reg + 16'h0001;
                        end
                    end
                end
                MODE_PULSE_WIDTH: begin
                    if (state_reg != CNT_RUN) begin
                        if (start_edge) begin
                            state_next = CNT_RUN;
                            cnt_next = 16'h0000;
                        end
                    end else if (stop_edge) begin
                        // Width lands in B; with option set, capture then waits for next pulse
                        capture_req = 1'b1;
                        irq_next = 1'b1;
                        cnt_next = 16'h0000;
                        if (option) state_next = CNT_IDLE;
                    end else if (src_tick && cnt_reg != 16'hFFFF) begin
                        cnt_next = cnt_reg + 16'h0001;
                    end
                end
                MODE_PULSE_OUT: begin
                    if (state_reg == CNT_IDLE) begin
                        if (start_f == START_COMMAND || start_edge) state_next = CNT_RUN;
                    end else if (state_reg == CNT_RUN && src_tick) begin
                        if (match_a) begin
                            cnt_next = 16'h0000;
                            irq_next = 1'b1;
                            out_next = !pulse_out;
                            // One-shot parks after a single period
                            if (option) state_next = CNT_HOLD;
                        end else begin
                            if (match_b) out_next = !pulse_out;
                            cnt_next = cnt_reg + 16'h0001;
                        end
                    end
                end
                default: state_next = CNT_IDLE;
            endcase
        end
    end

    // Counter registers and pin synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= CNT_IDLE;
            cnt_reg <= 16'h0000;
            match_interrupt <= 1'b0;
            pulse_out <= 1'b0;
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
            pin_prev_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            match_interrupt <= irq_next;
            pulse_out <= out_next;
            pin_meta_reg <= timer_pin;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

endmodule // timer_unit_one

`default_nettype wire

// >>> verif/timer_unit_one_chk.sv
// Concurrent checks on the ports of the timer register block
`timescale 1ns/1ps
`default_nettype none
module timer_unit_one_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [timer_unit_one_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic stop_mode_entry,
    input wire logic slow_mode,
    input wire logic divider_clock_option,
    input wire logic low_clk,
    input wire logic timer_pin,
    input wire logic match_interrupt,
    input wire logic pulse_out
);
    import timer_unit_one_pkg::*;
    // ----------------------------------------------------------------
    // Decode of the bus request
    // ----------------------------------------------------------------
    logic setup_c;
    logic mapped_c;
    assign setup_c = psel && !penable;
    assign mapped_c = paddr inside {ADDR_COMPARE_A, ADDR_COMPARE_B, ADDR_CONTROL};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------------------------------
    // Bus answer and register behaviour
    // ----------------------------------------------------------------
    a_ready_after_setup: assert property (setup_c |=> pready) else $error("no answer");
    a_ready_single: assert property (pready |=> !pready) else $error("answer too long");
    a_idle_quiet: assert property (!psel |=> !pready && !pslverr) else $error("stray answer");
    a_unmapped_err: assert property (setup_c && !mapped_c |=> pslverr && pready)
        else $error("unmapped not refused");
    a_mapped_ok: assert property (setup_c && mapped_c |=> !pslverr) else $error("bad error");
    a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    a_ctrl_width: assert property (pready && !pwrite && paddr == ADDR_CONTROL
        |-> prdata[31:8] == 24'h0) else $error("control upper bits set");
    a_irq_pulse: assert property ($rose(match_interrupt) |=> !match_interrupt)
        else $error("interrupt not a pulse");
    a_stop_halts: assert property (stop_mode_entry [*4] |-> !match_interrupt)
        else $error("interrupt while halted");
    a_stop_start_clear: assert property (stop_mode_entry [*3] ##0 (pready && !pwrite
        && paddr == ADDR_CONTROL) |-> prdata[5:4] == START_STOP) else $error("start kept");
endmodule // timer_unit_one_chk
bind timer_unit_one timer_unit_one_chk timer_unit_one_chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_mode_entry(stop_mode_entry), .slow_mode(slow_mode),
    .divider_clock_option(divider_clock_option), .low_clk(low_clk), .timer_pin(timer_pin),
    .match_interrupt(match_interrupt), .pulse_out(pulse_out));
`default_nettype wire

// >>> verif/pin_source.sv
// Behavioural model of the low-frequency clock and the external timer pin
`timescale 1ns/1ps
`default_nettype none
module pin_source (
    output logic low_clk,
    output logic timer_pin
);
    // Low clock runs free at 200 ns, its edges on bus clock falling edges, never on rising ones
    initial low_clk = 1'b0;
    always #100 low_clk = ~low_clk;
    // Pin rests low; no trigger or event traffic in these runs
    initial timer_pin = 1'b0;
endmodule // pin_source
`default_nettype wire

// >>> verif/test_timer_unit_one.sv
// Self-checking bench for the timer register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin err_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); end end
module test_timer_unit_one;
    import timer_unit_one_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] e;} row_s;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stop_mode_entry = 1'b0, slow_mode = 1'b0;
    logic divider_clock_option = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'h0;
    logic pready, pslverr, err, low_clk, timer_pin, match_interrupt, pulse_out;
    int err_count = 0, samples_checked = 0, n;
    // Control codes written then read back; last row lacks the low strobe
    row_s rows[9] = '{'{ADDR_CONTROL, 32'h0C, 4'hF, 32'h0C}, '{ADDR_CONTROL, 32'h08, 4'hF, 32'h08},
        '{ADDR_CONTROL, 32'h05, 4'hF, 32'h05}, '{ADDR_CONTROL, 32'h02, 4'hF, 32'h02},
        '{ADDR_CONTROL, 32'h03, 4'hF, 32'h03}, '{ADDR_CONTROL, 32'h23, 4'hF, 32'h23},
        '{ADDR_CONTROL, 32'h33, 4'hF, 32'h33}, '{ADDR_CONTROL, 32'h03, 4'hF, 32'h03},
        '{ADDR_CONTROL, 32'hFF, 4'h2, 32'h03}};
    timer_unit_one timer_unit_one_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .stop_mode_entry(stop_mode_entry),
        .slow_mode(slow_mode), .divider_clock_option(divider_clock_option), .low_clk(low_clk),
        .timer_pin(timer_pin), .match_interrupt(match_interrupt), .pulse_out(pulse_out));
    pin_source pin_source_i (.low_clk(low_clk), .timer_pin(timer_pin));
    always #12.5 pclk = ~pclk;
    // ----------------------------------------------------------------
    // Bus master: hold the request until pready is seen at an edge
    // ----------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog may end a wait for the answer
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wait_irq(input int lim);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (match_interrupt !== 1'b1 && n < lim);
    endtask
    task automatic check_reset;
        apb(1'b0, ADDR_COMPARE_A, 32'h0, 4'h0);
        `CHK("a reset", 32'hFFFF, rd)
        apb(1'b0, ADDR_COMPARE_B, 32'h0, 4'h0);
        `CHK("b reset", 32'hFFFF, rd)
        apb(1'b0, ADDR_CONTROL, 32'h0, 4'h0);
        `CHK("ctrl reset", 32'h0, rd)
        `CHK("pulse reset", 1'b0, pulse_out)
    endtask
    task automatic report_and_stop;
        if (err_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Hang guard, well beyond the under two thousand cycles the run needs
    initial begin
        repeat (8000) @(posedge pclk);
        err_count++;
        report_and_stop();
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        check_reset();
        apb(1'b0, 8'h44, 32'h0, 4'h0);
        `CHK("unmapped err", 1'b1, err)
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d, rows[i].s);
            apb(1'b0, rows[i].a, 32'h0, 4'h0);
            `CHK("ctrl row", rows[i].e, rd)
        end
        // Timer mode at divide by 8, loaded while stopped
        apb(1'b1, ADDR_CONTROL, 32'h08, 4'hF);
        apb(1'b1, ADDR_COMPARE_A, 32'h05, 4'h1);
        repeat (32) @(posedge pclk);
        apb(1'b0, ADDR_COMPARE_A, 32'h0, 4'h0);
        `CHK("a low only", 32'hFFFF, rd)
        apb(1'b1, ADDR_COMPARE_A, 32'h00, 4'h2);
        apb(1'b1, ADDR_COMPARE_B, 32'h03, 4'h3);
        repeat (32) @(posedge pclk);
        apb(1'b0, ADDR_COMPARE_A, 32'h0, 4'h0);
        `CHK("a paired", 32'h5, rd)
        apb(1'b0, ADDR_COMPARE_B, 32'h0, 4'h0);
        `CHK("b locked", 32'hFFFF, rd)
        apb(1'b1, ADDR_CONTROL, 32'h18, 4'hF);
        wait_irq(200);
        wait_irq(200);
        `CHK("match period", 48, n)
        // Auto-capture, tested in timer mode only, read while running
        apb(1'b1, ADDR_CONTROL, 32'h08, 4'hF);
        apb(1'b1, ADDR_CONTROL, 32'h48, 4'hF);
        apb(1'b1, ADDR_CONTROL, 32'h58, 4'hF);
        repeat (16) @(posedge pclk);
        apb(1'b0, ADDR_COMPARE_B, 32'h0, 4'h0);
        `CHK("capture range", 1'b1, rd <= 32'h5)
        stop_mode_entry <= 1'b1;
        apb(1'b0, ADDR_CONTROL, 32'h0, 4'h0);
        `CHK("stop clears start", 32'h48, rd)
        wait_irq(100);
        `CHK("halted", 1'b0, match_interrupt)
        stop_mode_entry <= 1'b0;
        // Slow mode: fast code gives no tick, code 00 runs off low clock
        slow_mode <= 1'b1;
        apb(1'b1, ADDR_CONTROL, 32'h18, 4'hF);
        wait_irq(120);
        `CHK("no fast tick", 1'b0, match_interrupt)
        apb(1'b1, ADDR_CONTROL, 32'h08, 4'hF);
        apb(1'b1, ADDR_CONTROL, 32'h00, 4'hF);
        apb(1'b1, ADDR_CONTROL, 32'h10, 4'hF);
        wait_irq(900);
        wait_irq(900);
        `CHK("low clock period", 384, n)
        // Divider option keeps code 00 on the low clock in normal mode
        slow_mode <= 1'b0;
        divider_clock_option <= 1'b1;
        wait_irq(900);
        `CHK("option period", 384, n)
        divider_clock_option <= 1'b0;
        // Pulse output mode at divide by 8: flip-flop bit set first, then register B
        apb(1'b1, ADDR_CONTROL, 32'h00, 4'hF);
        apb(1'b1, ADDR_CONTROL, 32'h0B, 4'hF);
        apb(1'b1, ADDR_CONTROL, 32'h8B, 4'hF);
        apb(1'b1, ADDR_COMPARE_B, 32'h02, 4'h3);
        repeat (32) @(posedge pclk);
        apb(1'b0, ADDR_COMPARE_B, 32'h0, 4'h0);
        `CHK("b in pulse mode", 32'h2, rd)
        `CHK("pulse idle level", 1'b1, pulse_out)
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        check_reset();
        report_and_stop();
    end
endmodule // test_timer_unit_one
`default_nettype wire
